// ---- logic/wsc_weekly_cmp.sv ----
// weekly schedule comparator with apb register access
`timescale 1ns/1ps
// Function
// - evaluates only while execution on, else off
// - init edge copies defaults into data registers
// - init ignored unless register sourcing selected
// - output follows day and time comparison
// - pulse mode: one scan at on entry
// - pulse mode: execution rise checks on entries
// - level mode: on at on, off at off
// - constant mode uses fixed default entries
// - three registers per entry from base
// - constant entries cannot change while running
// - register entries read fresh every scan
// - bad time or no day flags error
// - level mode: execution rise applies current state
// - higher entry wins on equal time
module wsc_weekly_cmp
  import wsc_pkg::*;
#(
  parameter int PARAM_BASE_REG  = 0,
  parameter int PARAM_SET_COUNT = 20,
  parameter int DREG_DEPTH      = 64
) (
  input  wire logic                      CORE_CLK,   // core clock, 40 MHz
  input  wire logic                      RESET_N,    // synchronous reset, active low
  input  wire logic                      PSEL,       // apb select
  input  wire logic                      PENABLE,    // apb access phase
  input  wire logic                      PWRITE,     // apb write
  input  wire logic [wsc_pkg::APB_AW-1:0] PADDR,     // apb byte address
  input  wire logic [31:0]               PWDATA,     // apb write data
  output logic      [31:0]               PRDATA,     // apb read data
  output logic                           PREADY,     // apb ready
  output logic                           PSLVERR,    // apb error, unmapped
  input  wire logic                      SCAN_TICK,  // start of a program scan
  input  wire logic [2:0]                CAL_DOW,    // weekday, 0 sunday
  input  wire logic [15:0]               CAL_TIME,   // bcd hhmm of calendar
  output logic                           WEEK_OUT,   // schedule output
  output logic                           EXEC_ERR    // sticky execution error
);
  localparam int          AW        = $clog2(DREG_DEPTH);
  localparam logic [AW-1:0] BASE_IDX = AW'(PARAM_BASE_REG);
  localparam logic [AW-1:0] LAST_W  = AW'(WORDS_PER_ENTRY * PARAM_SET_COUNT - 1);
  localparam logic [11:0] DREG_END  = 12'(ADDR_DREG_BASE + 12'(4 * DREG_DEPTH));

  wsc_state_t  state_reg;
  wsc_state_t  state_next;
  logic [3:0]  ctrl_reg;
  logic        out_reg;
  logic        err_reg;
  logic        rd_pend_reg;
  logic        init_prev_reg;
  logic        init_req_reg;
  logic        scan_req_reg;
  logic [AW-1:0] w_reg;
  logic [1:0]  sub_reg;
  logic        vld_d_reg;
  logic [1:0]  sub_d_reg;
  logic        last_d_reg;
  logic [15:0] cword_reg;
  wsc_entry_t  ent_reg;
  logic [13:0] now_reg;
  logic [14:0] best_age_reg;
  logic        best_on_reg;
  logic        exec_prev_reg;
  logic        fire_prev_reg;
  logic [13:0] fire_min_reg;

  // apb decode
  wire         apb_acc   = PSEL && PENABLE;
  wire         is_ctrl   = PADDR == ADDR_CTRL;
  wire         is_stat   = PADDR == ADDR_STATUS;
  wire         is_mem    = (PADDR >= ADDR_DREG_BASE) && (PADDR < DREG_END)
                           && (PADDR[1:0] == 2'h0);
  wire [11:0]  mem_off   = 12'(PADDR - ADDR_DREG_BASE);
  wire [AW-1:0] apb_idx  = mem_off[AW+1:2];
  wire         idle      = state_reg == ST_IDLE;
  wire         mem_ready = idle && (PWRITE || rd_pend_reg);
  wire         apb_done  = apb_acc && PREADY;
  wire         ctrl_wr   = apb_done && PWRITE && is_ctrl;
  wire         stat_wr   = apb_done && PWRITE && is_stat;
  wire         mem_wr    = apb_done && PWRITE && is_mem;
  wire         rd_issue  = apb_acc && is_mem && !PWRITE && idle && !rd_pend_reg;
  wire         busy      = !idle || vld_d_reg;

  assign PREADY  = is_mem ? mem_ready : 1'b1;
  assign PSLVERR = apb_acc && !(is_ctrl || is_stat || is_mem);

  // control bits
  wire exec_on  = ctrl_reg[CTRL_EXEC];
  wire pulse_on = ctrl_reg[CTRL_PULSE];
  wire rsrc_on  = ctrl_reg[CTRL_RSRC];
  wire init_rise = ctrl_reg[CTRL_INIT] && !init_prev_reg;

  // sequencer start, apb memory traffic keeps the port
  wire start_ok = idle && !(PSEL && is_mem);
  wire go_init  = start_ok && init_req_reg;
  wire go_scan  = start_ok && !init_req_reg && scan_req_reg;
  wire last_w   = w_reg == LAST_W;

  // memory ports
  logic [15:0] mem_rdata;
  logic [15:0] def_word;
  wire  [AW-1:0] seq_idx  = BASE_IDX + w_reg;
  wire  [AW-1:0] mem_raddr = (state_reg == ST_SCAN) ? seq_idx : apb_idx;
  wire  [AW-1:0] mem_waddr = (state_reg == ST_INIT) ? seq_idx : apb_idx;
  wire           mem_we    = (state_reg == ST_INIT) || mem_wr;
  wire  [15:0]   mem_wdata = (state_reg == ST_INIT) ? def_word : PWDATA[15:0];

  always_comb begin
    unique case (sub_reg)
      SUB_DAYS: def_word = DEF_ENTRY.days;
      SUB_ON:   def_word = DEF_ENTRY.on_time;
      default:  def_word = DEF_ENTRY.off_time;
    endcase
  end

  wsc_dreg_mem #(
    .W     (DW),
    .DEPTH (DREG_DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk   (CORE_CLK),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // word of the entry arriving this cycle
  wire [15:0] word_in  = rsrc_on ? mem_rdata : cword_reg;
  wire        got_days = vld_d_reg && (sub_d_reg == SUB_DAYS);
  wire        got_on   = vld_d_reg && (sub_d_reg == SUB_ON);
  wire        got_off  = vld_d_reg && (sub_d_reg == SUB_OFF);
  wire        scan_end = got_off && last_d_reg;

  logic [14:0] on_age;
  logic [14:0] off_age;

  wsc_time_eval u_on_eval (
    .days    (ent_reg.days[6:0]),
    .hhmm    (ent_reg.on_time),
    .now_min (now_reg),
    .age     (on_age)
  );

  wsc_time_eval u_off_eval (
    .days    (ent_reg.days[14:8]),
    .hhmm    (word_in),
    .now_min (now_reg),
    .age     (off_age)
  );

  // entry validity
  wire on_bad  = (ent_reg.on_time > ON_MAX) || (ent_reg.on_time[7:0] > MIN_MAX)
                 || wsc_bcd_bad(ent_reg.on_time);
  wire off_bad = (word_in > OFF_MAX) || (word_in[7:0] > MIN_MAX) || wsc_bcd_bad(word_in);
  wire day_bad = (ent_reg.days[6:0] == 7'h00) || (ent_reg.days[14:8] == 7'h00);
  wire ent_bad = got_off && (on_bad || off_bad || day_bad);

  // latest event so far, later entries win ties
  logic [14:0] cand_age;
  logic        cand_on;

  always_comb begin
    cand_age = best_age_reg;
    cand_on  = best_on_reg;
    if (got_off && !ent_bad) begin
      if (on_age <= cand_age) begin
        cand_age = on_age;
        cand_on  = 1'b1;
      end
      if (off_age <= cand_age) begin
        cand_age = off_age;
        cand_on  = 1'b0;
      end
    end
  end

  // output decision at the end of a scan
  wire exec_rise = exec_on && !exec_prev_reg;
  wire hit_now   = cand_age == 15'h0000;
  wire fire      = exec_on && hit_now && cand_on;
  // one pulse per minute, a later on minute may fire again
  wire new_min   = !fire_prev_reg || (fire_min_reg != now_reg);
  logic out_next;

  always_comb begin
    out_next = out_reg;
    if (scan_end) begin
      if (!exec_on) begin
        out_next = 1'b0;
      end else if (pulse_on) begin
        out_next = fire && (new_min || exec_rise);
      end else if (exec_rise || hit_now) begin
        out_next = cand_on;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (go_init) begin
          state_next = ST_INIT;
        end else if (go_scan) begin
          state_next = ST_SCAN;
        end
      end
      ST_INIT: begin
        if (last_w) begin
          state_next = ST_IDLE;
        end
      end
      ST_SCAN: begin
        if (last_w) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // word and sub-word counters
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N || go_init || go_scan || last_w) begin
      w_reg   <= '0;
      sub_reg <= SUB_DAYS;
    end else if (!idle) begin
      w_reg   <= w_reg + 1'b1;
      sub_reg <= (sub_reg == SUB_OFF) ? SUB_DAYS : 2'(sub_reg + 2'h1);
    end
  end

  // read pipeline tags
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      vld_d_reg  <= 1'b0;
      sub_d_reg  <= SUB_DAYS;
      last_d_reg <= 1'b0;
      cword_reg  <= '0;
    end else begin
      vld_d_reg  <= state_reg == ST_SCAN;
      sub_d_reg  <= sub_reg;
      last_d_reg <= (state_reg == ST_SCAN) && last_w;
      cword_reg  <= def_word;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ent_reg <= '0;
    end else if (got_days) begin
      ent_reg.days <= word_in;
    end else if (got_on) begin
      ent_reg.on_time <= word_in;
    end
  end

  // scan time snapshot and running best
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      now_reg      <= '0;
      best_age_reg <= MIN_PER_WEEK;
      best_on_reg  <= 1'b0;
    end else if (go_scan) begin
      now_reg      <= 14'(14'(CAL_DOW) * MIN_PER_DAY) + 14'(wsc_bcd_min(CAL_TIME));
      best_age_reg <= MIN_PER_WEEK;
      best_on_reg  <= 1'b0;
    end else begin
      best_age_reg <= cand_age;
      best_on_reg  <= cand_on;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      out_reg       <= 1'b0;
      exec_prev_reg <= 1'b0;
      fire_prev_reg <= 1'b0;
      fire_min_reg  <= '0;
    end else if (scan_end) begin
      out_reg       <= out_next;
      exec_prev_reg <= exec_on;
      fire_prev_reg <= fire;
      fire_min_reg  <= now_reg;
    end
  end

  // control register and request flags, set wins over clear
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      ctrl_reg      <= CTRL_RESET;
      init_prev_reg <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= PWDATA[3:0];
      end
      init_prev_reg <= ctrl_reg[CTRL_INIT];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      init_req_reg <= 1'b0;
      scan_req_reg <= 1'b0;
    end else begin
      init_req_reg <= (init_rise && rsrc_on) || (init_req_reg && !go_init);
      scan_req_reg <= SCAN_TICK || (scan_req_reg && !go_scan);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      err_reg <= 1'b0;
    end else begin
      err_reg <= ent_bad || (err_reg && !(stat_wr && PWDATA[ST_ERR]));
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= rd_issue || (rd_pend_reg && !apb_done);
    end
  end

  always_comb begin
    PRDATA = 32'h0000_0000;
    if (is_ctrl) begin
      PRDATA = {28'h0000000, ctrl_reg};
    end else if (is_stat) begin
      PRDATA[ST_OUT]  = out_reg;
      PRDATA[ST_ERR]  = err_reg;
      PRDATA[ST_BUSY] = busy;
    end else if (is_mem) begin
      PRDATA = {16'h0000, mem_rdata};
    end
  end

  assign WEEK_OUT = out_reg;
  assign EXEC_ERR = err_reg;
endmodule

// ---- logic/wsc_pkg.sv ----
// package: constants, types and helpers of the weekly schedule comparator
package wsc_pkg;
  localparam int          APB_AW          = 12;
  localparam int          DW              = 16;
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_STATUS     = 12'h004;
  localparam logic [11:0] ADDR_DREG_BASE  = 12'h100;
  localparam int          CTRL_EXEC       = 0;
  localparam int          CTRL_INIT       = 1;
  localparam int          CTRL_PULSE      = 2;
  localparam int          CTRL_RSRC       = 3;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  localparam int          ST_OUT          = 0;
  localparam int          ST_ERR          = 1;
  localparam int          ST_BUSY         = 2;
  localparam int          WORDS_PER_ENTRY = 3;
  localparam logic [1:0]  SUB_DAYS        = 2'h0;
  localparam logic [1:0]  SUB_ON          = 2'h1;
  localparam logic [1:0]  SUB_OFF         = 2'h2;
  localparam logic [13:0] MIN_PER_DAY     = 14'h05a0;
  localparam logic [14:0] MIN_PER_WEEK    = 15'h2760;
  localparam logic [15:0] ON_MAX          = 16'h2359;
  localparam logic [15:0] OFF_MAX         = 16'h2400;
  localparam logic [7:0]  MIN_MAX         = 8'h59;

  // one schedule entry: on days [6:0], off days [14:8], bcd hhmm times
  typedef struct packed {
    logic [15:0] days;
    logic [15:0] on_time;
    logic [15:0] off_time;
  } wsc_entry_t;

  localparam wsc_entry_t DEF_ENTRY = '{16'h3e3e, 16'h0800, 16'h1700};

  typedef enum {ST_IDLE, ST_INIT, ST_SCAN} wsc_state_t;

  // bcd hhmm to minutes of the day
  function automatic logic [10:0] wsc_bcd_min(input logic [15:0] t);
    logic [10:0] hh;
    logic [10:0] mm;
    hh = 11'(t[15:12]) * 11'h00a + 11'(t[11:8]);
    mm = 11'(t[7:4]) * 11'h00a + 11'(t[3:0]);
    return 11'(hh * 11'h03c + mm);
  endfunction

  // any bcd digit above nine
  function automatic logic wsc_bcd_bad(input logic [15:0] t);
    return (t[15:12] > 4'h9) || (t[11:8] > 4'h9) || (t[7:4] > 4'h9) || (t[3:0] > 4'h9);
  endfunction
endpackage

// ---- logic/wsc_dreg_mem.sv ----
// data register file holding the schedule words
`timescale 1ns/1ps
module wsc_dreg_mem #(
  parameter int W     = 16,
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clk,    // core clock
  input  wire logic          we,     // write strobe
  input  wire logic [AW-1:0] waddr,  // write index
  input  wire logic [W-1:0]  wdata,  // write word
  input  wire logic [AW-1:0] raddr,  // read index
  output logic      [W-1:0]  rdata   // registered read word
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule

// ---- logic/wsc_time_eval.sv ----
// age in minutes of the latest weekly event of one setting
`timescale 1ns/1ps
module wsc_time_eval
  import wsc_pkg::*;
(
  input  wire logic [6:0]  days,     // selected weekdays, bit 0 sunday
  input  wire logic [15:0] hhmm,     // bcd event time
  input  wire logic [13:0] now_min,  // current minute of the week
  output logic      [14:0] age       // minutes since event, week if none
);
  logic [14:0] t;
  logic [14:0] diff;

  always_comb begin
    t    = '0;
    diff = '0;
    age  = MIN_PER_WEEK;
    for (int d = 0; d < 7; d++) begin
      if (days[d]) begin
        t    = 15'(15'(d) * 15'(MIN_PER_DAY)) + 15'(wsc_bcd_min(hhmm));
        diff = 15'(15'(now_min) + MIN_PER_WEEK - t);
        if (diff >= MIN_PER_WEEK) begin
          diff = 15'(diff - MIN_PER_WEEK);
        end
        if (diff < age) begin
          age = diff;
        end
      end
    end
  end
endmodule

// ---- dv/wsc_weekly_cmp_sva.sv ----
// port checker for the weekly schedule comparator
`timescale 1ns/1ps
module wsc_weekly_cmp_sva
  import wsc_pkg::*;
#(
  parameter int PARAM_SET_COUNT = 20
) (
  input wire logic                       CORE_CLK,   // core clock
  input wire logic                       RESET_N,    // sync reset
  input wire logic                       PSEL,       // apb select
  input wire logic                       PENABLE,    // apb access
  input wire logic                       PWRITE,     // apb write
  input wire logic [wsc_pkg::APB_AW-1:0] PADDR,      // apb address
  input wire logic [31:0]                PWDATA,     // apb wdata
  input wire logic [31:0]                PRDATA,     // apb rdata
  input wire logic                       PREADY,     // apb ready
  input wire logic                       PSLVERR,    // apb error
  input wire logic                       SCAN_TICK,  // scan start
  input wire logic [2:0]                 CAL_DOW,    // weekday
  input wire logic [15:0]                CAL_TIME,   // bcd time
  input wire logic                       WEEK_OUT,   // output
  input wire logic                       EXEC_ERR    // error flag
);
  localparam int MAXW = 3 * PARAM_SET_COUNT + 10;
  logic       exec_reg;
  logic [7:0] since_reg;
  wire        acc_w = PSEL && PENABLE && PREADY && PWRITE;
  wire        clr_w = acc_w && PADDR == ADDR_STATUS && PWDATA[ST_ERR];
  wire        dat_a = PADDR[11:8] == 4'h1 && PADDR[1:0] == 2'h0;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // shadow of exec and cycles since last scan tick
  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      exec_reg  <= 1'b0;
      since_reg <= 8'hff;
    end else begin
      if (acc_w && PADDR == ADDR_CTRL) exec_reg <= PWDATA[CTRL_EXEC];
      since_reg <= SCAN_TICK ? 8'h00 : since_reg + 8'(since_reg != 8'hff);
    end
  end
  chk_ready_ctrl: assert property (PSEL && PENABLE && PADDR == ADDR_CTRL |-> PREADY)
    else $error("control access not ready at once");
  chk_unmapped_err: assert property (PSEL && PENABLE && PADDR == 12'h008
    |-> PREADY && PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
  chk_dread_wait: assert property ($rose(PENABLE) && PSEL && !PWRITE && dat_a |-> !PREADY)
    else $error("data read answered without wait");
  chk_status_mirror: assert property (PSEL && PENABLE && !PWRITE && PADDR == ADDR_STATUS
    |-> PRDATA[ST_OUT] == WEEK_OUT && PRDATA[ST_ERR] == EXEC_ERR) else $error("status bits wrong");
  chk_reset_off: assert property ($rose(RESET_N) |-> !WEEK_OUT && !EXEC_ERR)
    else $error("outputs not cleared by reset");
  chk_out_window: assert property ($changed(WEEK_OUT) |-> since_reg <= MAXW)
    else $error("output changed outside a scan");
  chk_out_rise_exec: assert property ($rose(WEEK_OUT) |-> exec_reg)
    else $error("output rose with exec off");
  chk_out_fall_only: assert property ($changed(WEEK_OUT) && !exec_reg |-> !WEEK_OUT)
    else $error("output changed to on with exec off");
  chk_err_sticky: assert property (EXEC_ERR && !clr_w |=> EXEC_ERR)
    else $error("error flag lost without clear");
  chk_err_rise: assert property ($rose(EXEC_ERR) |-> since_reg <= MAXW)
    else $error("error flag set outside a scan");
endmodule

bind wsc_weekly_cmp wsc_weekly_cmp_sva #(.PARAM_SET_COUNT(PARAM_SET_COUNT)) u_sva (
  .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SCAN_TICK(SCAN_TICK), .CAL_DOW(CAL_DOW), .CAL_TIME(CAL_TIME),
  .WEEK_OUT(WEEK_OUT), .EXEC_ERR(EXEC_ERR));

// ---- dv/wsc_cal_model.sv ----
// calendar and scan source model
`timescale 1ns/1ps
module wsc_cal_model (
  input  wire logic        clk,       // core clock
  input  wire logic        go,        // present new time and scan
  input  wire logic [2:0]  dow_in,    // weekday to present
  input  wire logic [15:0] time_in,   // bcd time to present
  output logic      [2:0]  cal_dow,   // weekday to block
  output logic      [15:0] cal_time,  // bcd time to block
  output logic             tick       // one-cycle scan start
);
  logic [2:0]  dow_reg  = 3'h0;
  logic [15:0] tim_reg  = 16'h0000;
  logic        tick_reg = 1'b0;
  assign cal_dow  = dow_reg;
  assign cal_time = tim_reg;
  assign tick     = tick_reg;
  // time lands with the tick, so the scan latches it
  always @(posedge clk) begin
    if (go) begin
      dow_reg <= dow_in;
      tim_reg <= time_in;
    end
    tick_reg <= go;
  end
endmodule

// ---- dv/testbench.sv ----
// testbench: apb tasks and schedule output tests
`timescale 1ns/1ps
module testbench;
  import wsc_pkg::*;
  localparam int NS = 2;
  localparam logic [15:0] TV [6] = '{16'h0101, 16'h0900, 16'h1000, 16'h0101, 16'h0800, 16'h0900};
  localparam int          EI [6] = '{1, 1, 2, 2, 0, 1};
  localparam logic [15:0] EV [6] = '{16'h2400, 16'h0860, 16'h2401, 16'h2400, 16'h0000, 16'h2359};
  localparam logic        EE [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  logic        clk;
  logic        rst_n = 1'b0;
  logic        psel  = 1'b0;
  logic        pen   = 1'b0;
  logic        pwr   = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwd   = 32'h0;
  logic        go    = 1'b0;
  logic [2:0]  gdow  = 3'h0;
  logic [15:0] gtim  = 16'h0;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic [2:0]  cdow;
  logic [15:0] ctim;
  logic        tick;
  logic        wout;
  logic        werr;
  logic [31:0] rq;
  logic        re;
  logic [15:0] ew;
  int          failures = 0;
  int          checks_done = 0;
  wsc_weekly_cmp #(.PARAM_BASE_REG(0), .PARAM_SET_COUNT(NS)) dut (
    .CORE_CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .SCAN_TICK(tick), .CAL_DOW(cdow), .CAL_TIME(ctim), .WEEK_OUT(wout), .EXEC_ERR(werr));
  wsc_cal_model cal (.clk(clk), .go(go), .dow_in(gdow), .time_in(gtim),
    .cal_dow(cdow), .cal_time(ctim), .tick(tick));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [11:0] da(input int i);
    return ADDR_DREG_BASE + 12'(4 * i);
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel  <= 1'b1;
    pwr   <= w;
    paddr <= a;
    pwd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rq = prd;
    re = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic sc(input logic [2:0] d, input logic [15:0] t);
    @(posedge clk);
    gdow <= d;
    gtim <= t;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3 * NS + 8) @(posedge clk);
  endtask
  // write control, run one scan, compare the output
  task automatic sx(input logic [3:0] c, input logic [2:0] d, input logic [15:0] t,
                    input logic e);
    apb(1'b1, ADDR_CTRL, {28'h0, c});
    sc(d, t);
    cmp({31'h0, wout}, {31'h0, e});
  endtask
  task automatic endt(input string s);
    $display("test %s done", s);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    cmp(rq, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    cmp({rq[30:0], re}, 32'h1);
    apb(1'b1, da(3 * NS), 32'h1234);
    apb(1'b1, da(0), 32'h0);
    endt("reset");
    sx(4'h1, 3'h1, 16'h0759, 1'b0);
    sx(4'h1, 3'h1, 16'h0800, 1'b1);
    sx(4'h1, 3'h1, 16'h1200, 1'b1);
    sx(4'h0, 3'h1, 16'h1200, 1'b0);
    sx(4'h1, 3'h1, 16'h1200, 1'b1);
    sx(4'h1, 3'h1, 16'h1700, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp(rq, 32'h0);
    endt("level");
    apb(1'b1, ADDR_CTRL, 32'h2);
    apb(1'b0, da(0), 32'h0);
    cmp(rq, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h8);
    apb(1'b1, ADDR_CTRL, 32'ha);
    // a selected data access holds the copy off, so let it start first
    repeat (2) @(posedge clk);
    for (int i = 0; i <= 3 * NS; i++) begin
      ew = (i % 3 == 0) ? DEF_ENTRY.days : (i % 3 == 1) ? DEF_ENTRY.on_time : DEF_ENTRY.off_time;
      apb(1'b0, da(i), 32'h0);
      cmp(rq, (i == 3 * NS) ? 32'h1234 : {16'h0, ew});
    end
    sx(4'h9, 3'h1, 16'h0800, 1'b1);
    endt("init");
    for (int i = 0; i < 6; i++) apb(1'b1, da(i), {16'h0, TV[i]});
    sx(4'h9, 3'h0, 16'h0800, 1'b1);
    sx(4'h9, 3'h0, 16'h0900, 1'b0);
    sx(4'h9, 3'h0, 16'h0959, 1'b0);
    apb(1'b1, da(5), 32'h1100);
    sx(4'h9, 3'h0, 16'h0900, 1'b1);
    sx(4'h9, 3'h0, 16'h1000, 1'b0);
    endt("order");
    sx(4'h8, 3'h0, 16'h0700, 1'b0);
    sx(4'hd, 3'h0, 16'h0800, 1'b1);
    sx(4'hd, 3'h0, 16'h0800, 1'b0);
    sx(4'hd, 3'h0, 16'h0900, 1'b1);
    sx(4'hd, 3'h0, 16'h1000, 1'b0);
    sx(4'h8, 3'h0, 16'h1000, 1'b0);
    sx(4'hd, 3'h0, 16'h0930, 1'b0);
    endt("pulse");
    apb(1'b1, ADDR_CTRL, 32'h9);
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, da(EI[k]), {16'h0, EV[k]});
      sc(3'h0, 16'h1200);
      apb(1'b0, ADDR_STATUS, 32'h0);
      cmp({31'h0, rq[ST_ERR]}, {31'h0, EE[k]});
      cmp({31'h0, werr}, {31'h0, EE[k]});
      apb(1'b1, ADDR_STATUS, 32'h2);
      apb(1'b1, da(EI[k]), {16'h0, TV[EI[k]]});
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    cmp({31'h0, rq[ST_ERR]}, 32'h0);
    endt("error");
    tally_and_finish();
  end
endmodule
